// ===== logic/status_cc_defines.svh
// Constants for the status LED and camera-control block
`ifndef STATUS_CC_DEFINES_SVH
`define STATUS_CC_DEFINES_SVH

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define OFS_CONFIG     12'h000
`define OFS_CC_ROUTE   12'h004
`define OFS_TRIG_PER   12'h008
`define OFS_PULSE_W    12'h00C
`define OFS_STATUS     12'h010

// ****************************************************************
// Field positions and mode reset value
// ****************************************************************
`define CFG_MODE_LO    0
`define CFG_MODE_HI    1
`define CFG_FIRST_BASE 2
`define CFG_POWER_EN   3
`define CFG_TRIG_EN    4
`define CFG_PULSE1_EN  5
`define CFG_MODE_RST   2'h1

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ          100000000
`define TRIG_STEP_NS    2000
`define TRIG_STEP_CYC   (`TRIG_STEP_NS / 10)
`define HOST_FLASH_HZ   2
`define SLOW_FLASH_HZ   1
`define FAST_FLASH_HZ   8
`define DETECT_WIN_CYC  20'h186A0
`define PULSE_W_RST     16'h000A

`endif

// ===== logic/status_cc_pkg.sv
// Types for the status LED and camera-control block
package status_cc_pkg;
    typedef enum logic [1:0] {MODE_BASE, MODE_MEDIUM, MODE_FULL, MODE_DECA} cl_mode_t;
    typedef enum logic [2:0] {SRC_LOW, SRC_HIGH, SRC_PULSE0, SRC_PULSE1, SRC_UNUSED} cc_src_t;
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } led_rgb_t;
    typedef struct packed {
        logic [3:0] clk_seen;
        logic [3:0] lval_seen;
    } detect_t;
endpackage : status_cc_pkg

// ===== logic/status_cc.sv
// Host-link and camera-link status LEDs with camera-control outputs
`include "status_cc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module status_cc
    import status_cc_pkg::*;
#(
    parameter int unsigned HOST_FLASH_CYC = `CLK_HZ / (2 * `HOST_FLASH_HZ),
    parameter int unsigned SLOW_FLASH_CYC = `CLK_HZ / (2 * `SLOW_FLASH_HZ),
    parameter int unsigned FAST_FLASH_CYC = `CLK_HZ / (2 * `FAST_FLASH_HZ),
    parameter int unsigned DETECT_CYC = `DETECT_WIN_CYC
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic IMAGE_LOADED_I,
    input wire logic SAFE_IMAGE_I,
    input wire logic FULL_IMAGE_I,
    input wire logic HOST_LINK_UP_I,
    input wire logic HOST_TRAIN_FAIL_I,
    input wire logic HOST_GEN2_I,
    input wire logic [2:0] HOST_LANES_I,
    input wire logic [3:0] PIX_CLK_I,
    input wire logic [3:0] LVAL_I,
    input wire logic [1:0] ACQ_ACTIVE_I,
    output logic [2:0] HOST_LINK_STATUS_LED_O,
    output logic [2:0] FIRST_LINK_STATUS_LED_O,
    output logic [2:0] SECOND_LINK_STATUS_LED_O,
    output logic [3:0] CAMERA_CTRL_O,
    output logic [3:0] CAMERA_CTRL_EN_O,
    output logic CAMERA_POWER_EN_O
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0] pclk_s1_r, pclk_s2_r, pclk_s3_r;
    logic [3:0] lval_s1_r, lval_s2_r;
    logic [1:0] acq_s1_r, acq_s2_r;
    logic [5:0] host_s1_r, host_s2_r;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pclk_s1_r <= 4'h0;
            pclk_s2_r <= 4'h0;
            pclk_s3_r <= 4'h0;
            lval_s1_r <= 4'h0;
            lval_s2_r <= 4'h0;
            acq_s1_r <= 2'h0;
            acq_s2_r <= 2'h0;
            host_s1_r <= 6'h00;
            host_s2_r <= 6'h00;
        end else begin
            pclk_s1_r <= PIX_CLK_I;
            pclk_s2_r <= pclk_s1_r;
            pclk_s3_r <= pclk_s2_r;
            lval_s1_r <= LVAL_I;
            lval_s2_r <= lval_s1_r;
            acq_s1_r <= ACQ_ACTIVE_I;
            acq_s2_r <= acq_s1_r;
            host_s1_r <= {IMAGE_LOADED_I, SAFE_IMAGE_I, HOST_TRAIN_FAIL_I,
                          HOST_GEN2_I, HOST_LINK_UP_I, HOST_LANES_I == 3'h4};
            host_s2_r <= host_s1_r;
        end
    end

    wire img_loaded = host_s2_r[5];
    wire img_safe = host_s2_r[4];
    wire train_fail = host_s2_r[3];
    wire gen2 = host_s2_r[2];
    wire link_up = host_s2_r[1];
    wire lanes_x4 = host_s2_r[0];

    // ****************************************************************
    // APB registers
    // ****************************************************************
    logic [4:0] cfg_r;
    logic cfg_pwr_r;
    logic [11:0] route_r;
    logic [15:0] trig_per_r;
    logic [15:0] pulse_w_r;
    logic [31:0] prdata_nxt;
    logic [1:0] mode_first_r;

    wire apb_acc = PSEL_I && PENABLE_I;
    wire apb_wr = apb_acc && PWRITE_I;
    wire hit_cfg = PADDR_I == `OFS_CONFIG;
    wire hit_route = PADDR_I == `OFS_CC_ROUTE;
    wire hit_per = PADDR_I == `OFS_TRIG_PER;
    wire hit_pw = PADDR_I == `OFS_PULSE_W;
    wire hit_stat = PADDR_I == `OFS_STATUS;
    wire hit_any = hit_cfg | hit_route | hit_per | hit_pw | hit_stat;
    wire [1:0] mode_bits = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
    wire first_base = cfg_r[`CFG_FIRST_BASE];
    wire trig_en = cfg_r[`CFG_TRIG_EN - 1];
    wire pulse1_en = cfg_r[`CFG_PULSE1_EN - 1];
    led_rgb_t first_led, second_led, host_led;
    detect_t det;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg_r <= {3'h0, `CFG_MODE_RST};
            cfg_pwr_r <= 1'b0;
            route_r <= 12'h000;
            trig_per_r <= 16'h0000;
            pulse_w_r <= `PULSE_W_RST;
        end else if (apb_wr) begin
            if (hit_cfg) begin
                cfg_r <= {PWDATA_I[`CFG_PULSE1_EN], PWDATA_I[`CFG_TRIG_EN],
                          PWDATA_I[`CFG_FIRST_BASE], PWDATA_I[`CFG_MODE_HI:`CFG_MODE_LO]};
                cfg_pwr_r <= PWDATA_I[`CFG_POWER_EN];
            end
            if (hit_route) begin
                route_r <= PWDATA_I[11:0];
            end
            if (hit_per) begin
                trig_per_r <= PWDATA_I[15:0];
            end
            if (hit_pw) begin
                pulse_w_r <= PWDATA_I[15:0];
            end
        end
    end

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_cfg) begin
            prdata_nxt = {26'h0, cfg_r[4], cfg_r[3], cfg_pwr_r, cfg_r[2:0]};
        end else if (hit_route) begin
            prdata_nxt = {20'h0, route_r};
        end else if (hit_per) begin
            prdata_nxt = {16'h0, trig_per_r};
        end else if (hit_pw) begin
            prdata_nxt = {16'h0, pulse_w_r};
        end else if (hit_stat) begin
            prdata_nxt = {13'h0, det, acq_s2_r, first_led, second_led, host_led};
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !hit_any;
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                PRDATA_O <= prdata_nxt;
            end
        end
    end

    // ****************************************************************
    // Flash dividers
    // ****************************************************************
    logic [31:0] host_cnt_r, slow_cnt_r, fast_cnt_r;
    logic host_ph_r, slow_ph_r, fast_ph_r;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            host_cnt_r <= 32'h0;
            slow_cnt_r <= 32'h0;
            fast_cnt_r <= 32'h0;
            host_ph_r <= 1'b0;
            slow_ph_r <= 1'b0;
            fast_ph_r <= 1'b0;
        end else begin
            host_cnt_r <= (host_cnt_r == HOST_FLASH_CYC - 1) ? 32'h0 : host_cnt_r + 32'h1;
            host_ph_r <= host_ph_r ^ (host_cnt_r == HOST_FLASH_CYC - 1);
            slow_cnt_r <= (slow_cnt_r == SLOW_FLASH_CYC - 1) ? 32'h0 : slow_cnt_r + 32'h1;
            slow_ph_r <= slow_ph_r ^ (slow_cnt_r == SLOW_FLASH_CYC - 1);
            fast_cnt_r <= (fast_cnt_r == FAST_FLASH_CYC - 1) ? 32'h0 : fast_cnt_r + 32'h1;
            fast_ph_r <= fast_ph_r ^ (fast_cnt_r == FAST_FLASH_CYC - 1);
        end
    end

    // ****************************************************************
    // Host-link LED
    // ****************************************************************
    wire host_on = gen2 | host_ph_r;

    always_comb begin
        host_led = '{red: 1'b1, green: 1'b0, blue: 1'b0};
        if (img_loaded) begin
            if (train_fail || !link_up) begin
                host_led = '{red: host_ph_r, green: 1'b0, blue: 1'b0};
            end else if (img_safe) begin
                host_led = '{red: 1'b0, green: 1'b0, blue: host_on};
            end else if (lanes_x4) begin
                host_led = '{red: 1'b0, green: host_on, blue: 1'b0};
            end else begin
                host_led = '{red: host_on, green: host_on, blue: 1'b0};
            end
        end
    end

    // ****************************************************************
    // Pixel clock and line valid detection
    // ****************************************************************
    logic [19:0] win_cnt_r;
    logic [3:0] clk_act_r, lval_act_r;
    wire win_end = win_cnt_r == DETECT_CYC[19:0] - 20'h1;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            win_cnt_r <= 20'h0;
        end else begin
            win_cnt_r <= win_end ? 20'h0 : win_cnt_r + 20'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_det
            logic clk_seen_r, lval_seen_r;
            always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
                if (SYS_RST_I) begin
                    clk_seen_r <= 1'b0;
                    lval_seen_r <= 1'b0;
                    clk_act_r[gi] <= 1'b0;
                    lval_act_r[gi] <= 1'b0;
                end else if (win_end) begin
                    clk_act_r[gi] <= clk_seen_r;
                    lval_act_r[gi] <= lval_seen_r;
                    clk_seen_r <= 1'b0;
                    lval_seen_r <= 1'b0;
                end else begin
                    clk_seen_r <= clk_seen_r | (pclk_s2_r[gi] & ~pclk_s3_r[gi]);
                    lval_seen_r <= lval_seen_r | lval_s2_r[gi];
                end
            end
        end
    endgenerate

    assign det = '{clk_seen: clk_act_r, lval_seen: lval_act_r};

    // ****************************************************************
    // Camera-link LEDs
    // ****************************************************************
    wire mode_full = mode_bits == MODE_FULL || mode_bits == MODE_DECA;
    wire mode_base = mode_bits == MODE_BASE;
    wire second_clk = mode_full ? &clk_act_r[2:1] : clk_act_r[1];
    wire second_lval = mode_full ? &lval_act_r[2:1] : lval_act_r[1];
    wire second_dead = mode_base || (FULL_IMAGE_I && first_base);

    function automatic led_rgb_t link_led(input logic clk_ok, input logic lval_ok,
                                          input logic acq, input logic slow, input logic fast);
        led_rgb_t l;
        l = '{red: 1'b1, green: 1'b0, blue: 1'b0};
        if (clk_ok && acq) begin
            l = '{red: 1'b0, green: fast, blue: 1'b0};
        end else if (clk_ok && lval_ok) begin
            l = '{red: 1'b0, green: slow, blue: 1'b0};
        end else if (clk_ok) begin
            l = '{red: 1'b0, green: 1'b1, blue: 1'b0};
        end
        return l;
    endfunction : link_led

    assign first_led = link_led(clk_act_r[0], lval_act_r[0], acq_s2_r[0],
                                slow_ph_r, fast_ph_r);
    assign second_led = second_dead ? '{red: 1'b1, green: 1'b0, blue: 1'b0} :
                        link_led(second_clk, second_lval, acq_s2_r[1], slow_ph_r, fast_ph_r);

    // ****************************************************************
    // Line trigger pulse generators
    // ****************************************************************
    logic [7:0] step_cnt_r;
    logic [15:0] per_cnt_r, pw_cnt_r;
    logic pulse0_r, pulse1_r;
    wire step_tick = step_cnt_r == 8'(`TRIG_STEP_CYC - 1);
    wire per_end = step_tick && (per_cnt_r >= trig_per_r - 16'h1);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            step_cnt_r <= 8'h00;
            per_cnt_r <= 16'h0000;
            pw_cnt_r <= 16'h0000;
            pulse0_r <= 1'b0;
            pulse1_r <= 1'b0;
        end else if (!trig_en || trig_per_r == 16'h0000) begin
            step_cnt_r <= 8'h00;
            per_cnt_r <= 16'h0000;
            pw_cnt_r <= 16'h0000;
            pulse0_r <= 1'b0;
            pulse1_r <= 1'b0;
        end else begin
            step_cnt_r <= step_tick ? 8'h00 : step_cnt_r + 8'h01;
            if (step_tick) begin
                per_cnt_r <= per_end ? 16'h0000 : per_cnt_r + 16'h0001;
            end
            if (per_end) begin
                pulse0_r <= 1'b1;
                pulse1_r <= pulse1_en;
                pw_cnt_r <= pulse_w_r;
            end else if (pw_cnt_r != 16'h0000) begin
                pw_cnt_r <= pw_cnt_r - 16'h0001;
            end else begin
                pulse0_r <= 1'b0;
                pulse1_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Camera-control routing and outputs
    // ****************************************************************
    logic [3:0] cc_nxt, cc_en_nxt;

    generate
        for (gi = 0; gi < 4; gi++) begin : g_cc
            wire [2:0] sel = route_r[3*gi +: 3];
            assign cc_nxt[gi] = (sel == SRC_HIGH) | (sel == SRC_PULSE0 && pulse0_r) |
                                (sel == SRC_PULSE1 && pulse1_r);
            assign cc_en_nxt[gi] = sel <= SRC_PULSE1;
        end
    endgenerate

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            HOST_LINK_STATUS_LED_O <= 3'h4;
            FIRST_LINK_STATUS_LED_O <= 3'h4;
            SECOND_LINK_STATUS_LED_O <= 3'h4;
            CAMERA_CTRL_O <= 4'h0;
            CAMERA_CTRL_EN_O <= 4'h0;
            CAMERA_POWER_EN_O <= 1'b0;
        end else begin
            HOST_LINK_STATUS_LED_O <= host_led;
            FIRST_LINK_STATUS_LED_O <= first_led;
            SECOND_LINK_STATUS_LED_O <= second_led;
            CAMERA_CTRL_O <= cc_nxt;
            CAMERA_CTRL_EN_O <= cc_en_nxt;
            CAMERA_POWER_EN_O <= cfg_pwr_r;
        end
    end

endmodule : status_cc
`default_nettype wire

// ===== tb/status_cc_props.sv
// Port checker for the status LED and camera-control block
`timescale 1ns/1ps
`default_nettype none
module status_cc_props
    import status_cc_pkg::*;
#(
    parameter int unsigned HOST_FLASH_CYC = 8,
    parameter int unsigned SLOW_FLASH_CYC = 16,
    parameter int unsigned FAST_FLASH_CYC = 4,
    parameter int unsigned DETECT_CYC = 64
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IMAGE_LOADED_I,
    input wire logic SAFE_IMAGE_I,
    input wire logic HOST_LINK_UP_I,
    input wire logic HOST_TRAIN_FAIL_I,
    input wire logic HOST_GEN2_I,
    input wire logic [2:0] HOST_LANES_I,
    input wire logic [3:0] PIX_CLK_I,
    input wire logic [2:0] HOST_LINK_STATUS_LED_O,
    input wire logic [2:0] FIRST_LINK_STATUS_LED_O,
    input wire logic [2:0] SECOND_LINK_STATUS_LED_O,
    input wire logic CAMERA_POWER_EN_O
);
    // ********************
    // Helper logic
    // ********************
    logic clk0_r;
    logic [15:0] idle_r;
    logic [15:0] idle_nxt;
    wire logic cfg_wr = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == 12'h000);
    wire logic host_up = IMAGE_LOADED_I & HOST_LINK_UP_I & ~HOST_TRAIN_FAIL_I & HOST_GEN2_I;
    // Cycles since the first pixel clock last moved
    assign idle_nxt = (PIX_CLK_I[0] != clk0_r) ? 16'h0000 :
        (idle_r == 16'hFFFF) ? idle_r : idle_r + 16'h0001;
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            clk0_r <= 1'b0;
            idle_r <= 16'h0000;
        end else begin
            clk0_r <= PIX_CLK_I[0];
            idle_r <= idle_nxt;
        end
    end
    // ********************
    // Assertions
    // ********************
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_reset_red_leds: assert property ($fell(SYS_RST_I) |-> !CAMERA_POWER_EN_O &&
        {HOST_LINK_STATUS_LED_O, FIRST_LINK_STATUS_LED_O, SECOND_LINK_STATUS_LED_O} == 9'h124)
        else $error("LEDs not red or power on after reset");
    a_ready_first_access: assert property (PSEL_I && !PENABLE_I |=> PREADY_O && PENABLE_I)
        else $error("No ready in the first access cycle");
    a_ready_one_cycle: assert property (PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O)
        else $error("Ready outside a single access cycle");
    a_err_unmapped: assert property (PREADY_O && PADDR_I > 12'h010 |-> PSLVERR_O)
        else $error("Unmapped address not refused");
    a_no_err_mapped: assert property (PREADY_O && PADDR_I <= 12'h010 && PADDR_I[1:0] == 2'h0
        |-> !PSLVERR_O) else $error("Mapped address refused");
    a_power_held: assert property ($fell(CAMERA_POWER_EN_O) |->
        $past(cfg_wr) || $past(cfg_wr, 2)) else $error("Power dropped without a write");
    a_host_red: assert property (!IMAGE_LOADED_I [*6] |-> HOST_LINK_STATUS_LED_O == 3'h4)
        else $error("Host LED not red without image");
    a_host_green: assert property ((host_up && !SAFE_IMAGE_I && HOST_LANES_I == 3'h4) [*6]
        |-> HOST_LINK_STATUS_LED_O == 3'h2) else $error("Host LED not solid green");
    a_host_yellow: assert property ((host_up && !SAFE_IMAGE_I && HOST_LANES_I != 3'h4) [*6]
        |-> HOST_LINK_STATUS_LED_O == 3'h6) else $error("Host LED not solid yellow");
    a_host_blue: assert property ((host_up && SAFE_IMAGE_I) [*6]
        |-> HOST_LINK_STATUS_LED_O == 3'h1) else $error("Host LED not solid blue");
    a_first_no_clock: assert property (idle_r > 2 * DETECT_CYC + 8
        |-> FIRST_LINK_STATUS_LED_O == 3'h4) else $error("First LED not red without clock");
endmodule : status_cc_props
bind status_cc status_cc_props #(.HOST_FLASH_CYC(HOST_FLASH_CYC), .SLOW_FLASH_CYC(SLOW_FLASH_CYC),
    .FAST_FLASH_CYC(FAST_FLASH_CYC), .DETECT_CYC(DETECT_CYC)) status_cc_props_i (.*);
`default_nettype wire

// ===== tb/camera_model.sv
// Camera model driving pixel clocks and line valids on both cables
`timescale 1ns/1ps
`default_nettype none
module camera_model (
    input wire logic [3:0] clk_en_i,
    input wire logic [3:0] lval_en_i,
    output logic [3:0] pix_clk_o,
    output logic [3:0] lval_o
);
    logic pclk;
    logic [3:0] line_cnt;
    // Free pixel clock, 80 ns, phase unrelated to the system clock
    initial begin
        pclk = 1'b0;
        line_cnt = 4'h0;
        #7;
        forever #40 pclk = ~pclk;
    end
    always @(posedge pclk) line_cnt <= line_cnt + 4'h1;
    // Stopped cable: clock and line valid stay low
    assign pix_clk_o = clk_en_i & {4{pclk}};
    // Low gap shorter than one detect window, so every window sees a line
    assign lval_o = lval_en_i & {4{|line_cnt[3:2]}};
endmodule : camera_model
`default_nettype wire

// ===== tb/status_cc_bench.sv
// Self-checking bench for the status LED and camera-control block
`timescale 1ns/1ps
`default_nettype none
module status_cc_bench;
    // ********************
    // Signals
    // ********************
    localparam int host_half = 8, slow_half = 16, fast_half = 4, detect_win = 64;
    logic clk, rst, psel, pen, pwrite, img, safe, full, up, fail, gen2, pready, pslverr, pwr_en, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] lanes, led_h, led_1, led_2;
    logic [3:0] clk_en, lval_en, pix, lval, cc, cc_en;
    logic [1:0] acq;
    int errors, n_compared, k;
    // Host inputs {image, safe, fail, up, gen2, lanes}, expected colour, flashing
    logic [11:0] host_tab [8] = '{12'h008, 12'h9C4, 12'h945, 12'h9AC, 12'h91D, 12'hDC2,
        12'hD23, 12'hA09};
    status_cc #(.HOST_FLASH_CYC(host_half), .SLOW_FLASH_CYC(slow_half), .FAST_FLASH_CYC(fast_half),
        .DETECT_CYC(detect_win)) status_cc_i (
        .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .IMAGE_LOADED_I(img), .SAFE_IMAGE_I(safe), .FULL_IMAGE_I(full),
        .HOST_LINK_UP_I(up), .HOST_TRAIN_FAIL_I(fail), .HOST_GEN2_I(gen2), .HOST_LANES_I(lanes),
        .PIX_CLK_I(pix), .LVAL_I(lval), .ACQ_ACTIVE_I(acq), .HOST_LINK_STATUS_LED_O(led_h),
        .FIRST_LINK_STATUS_LED_O(led_1), .SECOND_LINK_STATUS_LED_O(led_2),
        .CAMERA_CTRL_O(cc), .CAMERA_CTRL_EN_O(cc_en), .CAMERA_POWER_EN_O(pwr_en)
    );
    camera_model camera_model_i (.clk_en_i(clk_en), .lval_en_i(lval_en), .pix_clk_o(pix),
        .lval_o(lval));
    // ********************
    // Tasks
    // ********************
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, pen, pwdata} <= {2'h0, ~d};
        if (n >= 20) errors++;
    endtask : apb
    // Sample one LED for 48 cycles; half is the flash half period, 0 for solid
    task automatic led(input int sel, input logic [2:0] exp, input int half);
        logic [2:0] v, p;
        logic bad, ok;
        int tog;
        tog = 0;
        bad = 1'b0;
        repeat (200) @(posedge clk);
        for (int i = 0; i < 48; i++) begin
            @(posedge clk);
            v = (sel == 0) ? led_h : (sel == 1) ? led_1 : led_2;
            if (i > 0 && v !== p) tog++;
            if (v !== exp && (half == 0 || v !== 3'h0)) bad = 1'b1;
            p = v;
        end
        ok = !bad && ((half == 0) ? tog == 0 : (tog >= 47 / half && tog <= 47 / half + 1));
        cmp({28'h0, ok, exp}, {28'h0, 1'b1, exp});
    endtask : led
    task automatic wait_cc(input logic lvl);
        while (cc[2] !== lvl && k < 1000) begin
            @(posedge clk);
            k++;
        end
    endtask : wait_cc
    // ********************
    // Clock, watchdog, tests
    // ********************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        results();
    end
    initial begin
        {rst, psel, pen, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0000_0000};
        {img, safe, full, up, fail, gen2, lanes, acq, clk_en, lval_en} = {6'h08, 13'h0000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (host_tab[i]) begin
            {img, safe, fail, up, gen2, lanes} <= host_tab[i][11:4];
            led(0, host_tab[i][3:1], host_tab[i][0] ? host_half : 0);
        end
        led(1, 3'h4, 0);
        clk_en <= 4'h1;
        led(1, 3'h2, 0);
        led(2, 3'h4, 0);
        lval_en <= 4'h1;
        led(1, 3'h2, slow_half);
        acq <= 2'h1;
        led(1, 3'h2, fast_half);
        clk_en <= 4'h3;
        led(2, 3'h2, 0);
        lval_en <= 4'h3;
        led(2, 3'h2, slow_half);
        apb(1'b1, 12'h000, 32'h0000_0002);
        led(2, 3'h4, 0);
        clk_en <= 4'h7;
        led(2, 3'h2, 0);
        lval_en <= 4'h7;
        led(2, 3'h2, slow_half);
        apb(1'b1, 12'h000, 32'h0000_0006);
        led(2, 3'h4, 0);
        apb(1'b1, 12'h000, 32'h0000_0000);
        led(2, 3'h4, 0);
        // Pulse of 4 cycles every 400 cycles on CC3
        apb(1'b1, 12'h00C, 32'h0000_0003);
        apb(1'b1, 12'h008, 32'h0000_0002);
        apb(1'b1, 12'h004, 32'h0000_0881);
        apb(1'b1, 12'h000, 32'h0000_0019);
        apb(1'b0, 12'h004, 32'h0000_0000);
        cmp(rd, 32'h0000_0881);
        cmp({25'h0, pwr_en, cc_en, cc[1:0]}, 32'h0000_005D);
        k = 0;
        wait_cc(1'b1);
        k = 0;
        wait_cc(1'b0);
        cmp(k, 32'h0000_0004);
        wait_cc(1'b1);
        cmp(k, 32'h0000_0190);
        apb(1'b1, 12'h004, 32'h0000_0681);
        apb(1'b0, 12'h020, 32'h0000_0000);
        cmp({31'h0, er}, 32'h0000_0001);
        cmp(rd, 32'h0000_0000);
        cmp({28'h0, cc_en}, 32'h0000_000F);
        apb(1'b1, 12'h004, 32'h0000_0908);
        apb(1'b0, 12'h004, 32'h0000_0000);
        cmp({25'h0, pwr_en, cc_en, cc[1:0]}, 32'h0000_004E);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        cmp({31'h0, pwr_en}, 32'h0000_0000);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0000_0000);
        cmp(rd, 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        cmp(rd, 32'h0000_000A);
        results();
    end
endmodule : status_cc_bench
`default_nettype wire
